//--- dv/siit_timer_asserts.sv
// port checker for the scheduled interrupt interval timer
`timescale 1ns/1ns
module siit_timer_asserts
  import siit_pkg::*;
(
  // clock, reset, setup and command inputs
  input wire logic        CLK_SYS_IN,
  input wire logic        RST_B_IN,
  input wire logic        SETUP_WR_IN,
  input wire logic [7:0]  SETUP_ADDR_IN,
  input wire logic [3:0]  SETUP_WDATA_IN,
  input wire logic        CMD_VALID_IN,
  input wire siit_op_t    CMD_OP_IN,
  input wire logic [4:0]  CMD_CODE_IN,
  input wire logic        CMD_PROHIBIT_IN,
  // observed outputs
  input wire logic [3:0]  SETUP_RDATA_OUT,
  input wire logic        CMD_DONE_OUT,
  input wire logic        CMD_ERROR_OUT,
  input wire logic [15:0] CMD_RDATA_OUT,
  input wire logic [1:0]  SCHED_IRQ_OUT,
  input wire logic [1:0]  CH_RUNNING_OUT
);
  default clocking cb @(posedge CLK_SYS_IN); endclocking
  default disable iff (!RST_B_IN);
  // every command is answered exactly one cycle later
  chk_done_timing: assert property (CMD_DONE_OUT == $past(CMD_VALID_IN))
    else $error("done does not follow command by one cycle");
  chk_error_done: assert property (CMD_ERROR_OUT |-> CMD_DONE_OUT)
    else $error("error without done");
  chk_unit_readback: assert property (SETUP_WR_IN && SETUP_ADDR_IN == 8'hc3
    |-> ##2 SETUP_RDATA_OUT == $past(SETUP_WDATA_IN, 2)) else $error("unit readback wrong");
  chk_reset_start: assert property (CMD_DONE_OUT && !CMD_ERROR_OUT && $past(CMD_VALID_IN
    && CMD_OP_IN == SIIT_OP_SET && CMD_CODE_IN == 5'h0e && !CMD_PROHIBIT_IN)
    |=> CH_RUNNING_OUT[0]) else $error("channel 0 not running after start");
  // a prohibited channel 0 stays quiet for 8 cycles once the stop has crossed the pipeline
  chk_prohibit_quiet: assert property (CMD_VALID_IN && CMD_OP_IN == SIIT_OP_SET
    && (CMD_CODE_IN == 5'h04 || CMD_CODE_IN == 5'h0e) && CMD_PROHIBIT_IN
    |-> ##4 !SCHED_IRQ_OUT[0] [*8]) else $error("interrupt after prohibit");
  chk_rdata_hold: assert property ($changed(CMD_RDATA_OUT)
    |-> $past(CMD_VALID_IN && CMD_OP_IN == SIIT_OP_READ)) else $error("read data moved");
  chk_irq_running: assert property (SCHED_IRQ_OUT[0]
    |-> CH_RUNNING_OUT[0] || $past(CH_RUNNING_OUT[0])) else $error("irq on idle channel");
  chk_irq_pulse: assert property (SCHED_IRQ_OUT[0] |=> !SCHED_IRQ_OUT[0])
    else $error("irq longer than one cycle");
endmodule : siit_timer_asserts

bind siit_timer siit_timer_asserts u_chk (.CLK_SYS_IN, .RST_B_IN, .SETUP_WR_IN,
  .SETUP_ADDR_IN, .SETUP_WDATA_IN, .CMD_VALID_IN, .CMD_OP_IN, .CMD_CODE_IN,
  .CMD_PROHIBIT_IN, .SETUP_RDATA_OUT, .CMD_DONE_OUT, .CMD_ERROR_OUT, .CMD_RDATA_OUT,
  .SCHED_IRQ_OUT, .CH_RUNNING_OUT);

//--- dv/testbench.sv
// self-checking bench for the scheduled interrupt interval timer
`timescale 1ns/1ns
module testbench;
  import siit_pkg::*;
  typedef struct {logic [3:0] u; siit_op_t o; logic [4:0] c; logic p;
                  logic [15:0] v; logic e; logic [15:0] r;} siit_tb_row_t;
  logic        clk = 1'b0, rst_b = 1'b0, wr = 1'b0, cv = 1'b0, pr = 1'b0, done, err;
  logic [7:0]  addr = 8'hc3;
  logic [3:0]  unit = 4'h0, rdu;
  logic [4:0]  code = 5'h00;
  logic [15:0] iv = 16'h0000, rd, lo, hi;
  logic [1:0]  irq, run;
  siit_op_t    op = SIIT_OP_IDLE;
  int          fail_count = 0, n_compared = 0, n;
  // short prescaler counts keep periods to a few cycles
  siit_tb_row_t rows [12] = '{
    '{4'h2, SIIT_OP_SET, 5'h04, 1'b0, 16'h0004, 1'b1, 16'h0000},
    '{4'h2, SIIT_OP_SET, 5'h04, 1'b0, 16'h0005, 1'b0, 16'h0000},
    '{4'h2, SIIT_OP_SET, 5'h04, 1'b0, 16'h270f, 1'b0, 16'h0000},
    '{4'h2, SIIT_OP_SET, 5'h04, 1'b0, 16'h2710, 1'b1, 16'h0000},
    '{4'h1, SIIT_OP_READ, 5'h04, 1'b0, 16'h0000, 1'b0, 16'h270f},
    '{4'h1, SIIT_OP_SET, 5'h05, 1'b0, 16'h0000, 1'b1, 16'h0000},
    '{4'h1, SIIT_OP_SET, 5'h0f, 1'b0, 16'h0007, 1'b0, 16'h0000},
    '{4'h0, SIIT_OP_READ, 5'h05, 1'b0, 16'h0000, 1'b0, 16'h0007},
    '{4'h0, SIIT_OP_SET, 5'h06, 1'b0, 16'h0003, 1'b1, 16'h0000},
    '{4'h0, SIIT_OP_IDLE, 5'h04, 1'b0, 16'h0003, 1'b1, 16'h0000},
    '{4'h0, SIIT_OP_SET, 5'h04, 1'b1, 16'h0003, 1'b0, 16'h0000},
    '{4'h0, SIIT_OP_SET, 5'h05, 1'b1, 16'h0003, 1'b0, 16'h0000}};
  always #2 clk = ~clk;
  siit_timer #(.TICK_10MS_CYC(4), .TICK_1MS_CYC(3), .TICK_100US_CYC(2)) u_dut (
    .CLK_SYS_IN(clk), .RST_B_IN(rst_b), .SETUP_WR_IN(wr), .SETUP_ADDR_IN(addr),
    .SETUP_WDATA_IN(unit), .SETUP_RDATA_OUT(rdu), .CMD_VALID_IN(cv), .CMD_OP_IN(op),
    .CMD_CODE_IN(code), .CMD_PROHIBIT_IN(pr), .CMD_INTERVAL_IN(iv), .CMD_DONE_OUT(done),
    .CMD_ERROR_OUT(err), .CMD_RDATA_OUT(rd), .SCHED_IRQ_OUT(irq), .CH_RUNNING_OUT(run));
  task automatic check(string nm, logic [15:0] seen, logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  task automatic finish_test();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : finish_test
  // one write strobe, then two cycles so the readback has settled
  task automatic setup(logic [7:0] a, logic [3:0] u);
    addr <= a;
    unit <= u;
    wr   <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    repeat (2) @(posedge clk);
  endtask : setup
  // done has a fixed latency of one cycle, so no polling is needed
  task automatic cmd(siit_op_t o, logic [4:0] c, logic p, logic [15:0] v, logic e);
    op   <= o;
    code <= c;
    pr   <= p;
    iv   <= v;
    cv   <= 1'b1;
    @(posedge clk);
    cv <= 1'b0;
    #1;
    check("done", done, 16'h0001);
    check("error", err, e);
    @(posedge clk);
  endtask : cmd
  // counts edges until the chosen channel pulses; bounded so a dead channel cannot hang
  task automatic wait_irq(int ch);
    n = 0;
    do begin
      @(posedge clk);
      #1;
      n++;
    end while (irq[ch] !== 1'b1 && n < 60);
    if (n >= 60) begin
      check("irq timeout", 16'h0000, 16'h0001);
      finish_test();
    end
  endtask : wait_irq
  initial begin
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    #1;
    check("unit reset", rdu, 16'h0000);
    @(posedge clk);
    foreach (rows[i]) begin
      setup(8'hc3, rows[i].u);
      check("unit", rdu, rows[i].u);
      cmd(rows[i].o, rows[i].c, rows[i].p, rows[i].v, rows[i].e);
      if (rows[i].o == SIIT_OP_READ) check("read", rd, rows[i].r);
    end
    // a write to a neighbouring address must leave the unit alone
    setup(8'hc4, 4'h2);
    check("unit kept", rdu, 16'h0000);
    // reset start at 1 ms unit, 3 units of 3 cycles each
    setup(8'hc3, 4'h1);
    cmd(SIIT_OP_SET, 5'h0e, 1'b0, 16'h0003, 1'b0);
    wait_irq(0);
    wait_irq(0);
    check("period", n[15:0], 16'h0009);
    @(posedge clk);
    // live counter read back to back over one full period, in units
    op   <= SIIT_OP_READ;
    cv   <= 1'b1;
    lo = 16'hffff;
    hi = 16'h0000;
    repeat (9) begin
      @(posedge clk);
      #1;
      if (rd < lo) lo = rd;
      if (rd > hi) hi = rd;
    end
    cv <= 1'b0;
    check("count min", lo, 16'h0000);
    check("count max", hi, 16'h0002);
    @(posedge clk);
    // normal restart keeps the count; a clear four cycles after an interrupt
    // lands on a tick, so only a cleared counter gives a full 9-cycle delay
    cmd(SIIT_OP_SET, 5'h04, 1'b0, 16'h0003, 1'b0);
    wait_irq(0);
    repeat (4) @(posedge clk);
    cmd(SIIT_OP_CLEAR, 5'h04, 1'b0, 16'h0003, 1'b0);
    wait_irq(0);
    check("first delay", n[15:0], 16'h0009);
    @(posedge clk);
    // one-shot use: reset start was issued, the handler prohibits the channel
    cmd(SIIT_OP_SET, 5'h0e, 1'b1, 16'h0003, 1'b0);
    repeat (40) @(posedge clk);
    check("run after stop", {14'h0000, run}, 16'h0000);
    // reset with both channels stopped must drop the unit and the stored intervals
    rst_b <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    check("unit after reset", rdu, 16'h0000);
    @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    cmd(SIIT_OP_READ, 5'h04, 1'b0, 16'h0000, 1'b0);
    check("ival after reset", rd, 16'h0000);
    // channel 1 at 0.1 ms unit: 5 units of 2 cycles between pulses
    setup(8'hc3, 4'h2);
    cmd(SIIT_OP_SET, 5'h0f, 1'b0, 16'h0005, 1'b0);
    wait_irq(1);
    wait_irq(1);
    check("period ch1", n[15:0], 16'h000a);
    finish_test();
  end
endmodule : testbench

//--- logic/siit_cfg.svh
// constants for the scheduled interrupt interval timer
`ifndef SIIT_CFG_SVH
`define SIIT_CFG_SVH
`define SIIT_UNIT_OFFSET      8'hc3
`define SIIT_UNIT_RESET       4'h0
`define SIIT_UNIT_10MS        4'h0
`define SIIT_UNIT_1MS         4'h1
`define SIIT_UNIT_100US       4'h2
`define SIIT_CLK_NS           4
`define SIIT_TICK_10MS_NS     10000000
`define SIIT_TICK_1MS_NS      1000000
`define SIIT_TICK_100US_NS    100000
`define SIIT_TICK_10MS_CYC    (`SIIT_TICK_10MS_NS / `SIIT_CLK_NS)
`define SIIT_TICK_1MS_CYC     (`SIIT_TICK_1MS_NS / `SIIT_CLK_NS)
`define SIIT_TICK_100US_CYC   (`SIIT_TICK_100US_NS / `SIIT_CLK_NS)
`define SIIT_CODE_CH0         5'h04
`define SIIT_CODE_CH1         5'h05
`define SIIT_CODE_CH0_RST     5'h0e
`define SIIT_CODE_CH1_RST     5'h0f
`define SIIT_MIN_FAST         16'h0002
`define SIIT_MIN_SLOW         16'h0005
`define SIIT_MAX_100US        16'h270f
`endif

//--- logic/siit_channel.sv
// one scheduled interrupt channel: interval counter and pulse
`timescale 1ns/1ns
`include "siit_cfg.svh"
module siit_channel
  import siit_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire logic        tick,
  input  wire logic        start,
  input  wire logic        clear_cnt,
  input  wire logic        stop,
  input  wire logic [15:0] interval,
  output logic             running,
  output logic [15:0]      elapsed,
  output logic             fire
);
  siit_ch_state_t state_r, state_nxt;
  logic [15:0]    cnt_r, cnt_nxt;
  logic           fire_r, fire_nxt;

  // next state: counts ticks, fires and reloads at the interval
  always_comb begin
    state_nxt = state_r;
    cnt_nxt   = cnt_r;
    fire_nxt  = 1'b0;
    if (clear_cnt) begin
      cnt_nxt = 16'h0000; // RULE_05
    end
    case (state_r)
      SIIT_CH_OFF: begin
        if (start) begin
          state_nxt = SIIT_CH_RUN; // RULE_04
        end
      end
      SIIT_CH_RUN: begin
        if (stop) begin
          state_nxt = SIIT_CH_OFF; // RULE_12
        end else if (tick && !clear_cnt) begin
          // counter holds elapsed units since the last clear or last interrupt
          if (cnt_r + 16'h0001 >= interval) begin
            cnt_nxt  = 16'h0000; // RULE_13
            fire_nxt = 1'b1; // RULE_07
          end else begin
            cnt_nxt = cnt_r + 16'h0001; // RULE_09
          end
        end
      end
      default: state_nxt = SIIT_CH_OFF;
    endcase
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_r <= SIIT_CH_OFF;
      cnt_r   <= 16'h0000;
      fire_r  <= 1'b0;
    end else begin
      state_r <= state_nxt;
      cnt_r   <= cnt_nxt;
      fire_r  <= fire_nxt;
    end
  end

  assign running = (state_r == SIIT_CH_RUN);
  assign elapsed = cnt_r;
  assign fire    = fire_r;
endmodule : siit_channel

//--- logic/siit_pkg.sv
// types for the scheduled interrupt interval timer
package siit_pkg;
  typedef enum logic [1:0] {
    SIIT_OP_IDLE   = 2'b00,
    SIIT_OP_SET    = 2'b01,
    SIIT_OP_READ   = 2'b10,
    SIIT_OP_CLEAR  = 2'b11
  } siit_op_t;
  typedef enum logic [0:0] {
    SIIT_CH_OFF = 1'b0,
    SIIT_CH_RUN = 1'b1
  } siit_ch_state_t;
endpackage : siit_pkg

//--- logic/siit_timer.sv
// scheduled interrupt interval timer top level
//
// Notes on behaviour
// [RULE_01] unit field: 0 is 10 ms, 1 is 1 ms, 2 is 0.1 ms; resets to 0
// [RULE_02] period equals unit times the interval given with the set command
// [RULE_03] at 0.1 ms unit, accept 0.2 (fast) or 0.5 ms up to 999.9 ms
// [RULE_04] set codes 4 and 5 start channel 0 or 1, counter kept
// [RULE_05] set codes 14 and 15 clear the counter then start the channel
// [RULE_06] software issues clear command after normal start for a fixed first delay
// [RULE_07] interval is time between two successive interrupts on one channel
// [RULE_08] read codes 4 and 5 give interval, 14 and 15 give live counter
// [RULE_09] counter shows time since start or since the last interrupt; a start with set codes 4 and 5 keeps the old count
// [RULE_10] counter is read back in the selected time unit
// [RULE_11] one-shot: software sets output, reset-starts, clears it in the handler
// [RULE_12] a prohibit command stops interrupts of that channel
// [RULE_13] a running channel fires every interval and reloads until prohibited
`timescale 1ns/1ns
`include "siit_cfg.svh"
module siit_timer
  import siit_pkg::*;
#(
  parameter int TICK_10MS_CYC  = `SIIT_TICK_10MS_CYC,
  parameter int TICK_1MS_CYC   = `SIIT_TICK_1MS_CYC,
  parameter int TICK_100US_CYC = `SIIT_TICK_100US_CYC,
  parameter bit FAST_VARIANT   = 1'b0
)
(
  // clock and reset
  input  wire logic        CLK_SYS_IN,
  input  wire logic        RST_B_IN,
  // setup register port
  input  wire logic        SETUP_WR_IN,
  input  wire logic [7:0]  SETUP_ADDR_IN,
  input  wire logic [3:0]  SETUP_WDATA_IN,
  output logic      [3:0]  SETUP_RDATA_OUT,
  // command port
  input  wire logic        CMD_VALID_IN,
  input  wire siit_op_t    CMD_OP_IN,
  input  wire logic [4:0]  CMD_CODE_IN,
  input  wire logic        CMD_PROHIBIT_IN,
  input  wire logic [15:0] CMD_INTERVAL_IN,
  output logic             CMD_DONE_OUT,
  output logic             CMD_ERROR_OUT,
  output logic [15:0]      CMD_RDATA_OUT,
  // scheduled interrupts
  output logic [1:0]       SCHED_IRQ_OUT,
  output logic [1:0]       CH_RUNNING_OUT
);
  logic [3:0]  unit_r, unit_nxt;
  logic [3:0]  unit_rd_r, unit_rd_nxt;
  logic [15:0] ival_r [2];
  logic [15:0] ival_nxt [2];
  logic [31:0] pre_r, pre_nxt;
  logic        tick_r, tick_nxt;
  logic        done_r, done_nxt;
  logic        err_r, err_nxt;
  logic [15:0] rdata_r, rdata_nxt;
  logic [1:0]  irq_r, irq_nxt;
  logic [1:0]  run_r, run_nxt;
  logic [1:0]  start, clear_cnt, stop, running, fire;
  logic [15:0] elapsed [2];

  // prescaler length for the selected unit
  function automatic logic [31:0] unit_cycles(input logic [3:0] u);
    case (u)
      `SIIT_UNIT_1MS:   unit_cycles = 32'(TICK_1MS_CYC);
      `SIIT_UNIT_100US: unit_cycles = 32'(TICK_100US_CYC);
      default:          unit_cycles = 32'(TICK_10MS_CYC);
    endcase
  endfunction : unit_cycles

  // interval range check; only the 0.1 ms unit has a documented range
  function automatic logic interval_ok(input logic [3:0] u, input logic [15:0] v);
    logic [15:0] lo;
    lo = FAST_VARIANT ? `SIIT_MIN_FAST : `SIIT_MIN_SLOW;
    if (u == `SIIT_UNIT_100US) begin
      interval_ok = (v >= lo) && (v <= `SIIT_MAX_100US); // RULE_03
    end else begin
      interval_ok = (v != 16'h0000);
    end
  endfunction : interval_ok

  // command decode into channel controls
  always_comb begin
    start     = 2'b00;
    clear_cnt = 2'b00;
    stop      = 2'b00;
    if (CMD_VALID_IN && CMD_OP_IN == SIIT_OP_SET) begin
      case (CMD_CODE_IN)
        `SIIT_CODE_CH0, `SIIT_CODE_CH1: begin
          if (CMD_PROHIBIT_IN) begin
            stop[CMD_CODE_IN[0]] = 1'b1; // RULE_12
          end else if (interval_ok(unit_r, CMD_INTERVAL_IN)) begin
            start[CMD_CODE_IN[0]] = 1'b1; // RULE_04
          end
        end
        `SIIT_CODE_CH0_RST, `SIIT_CODE_CH1_RST: begin
          if (CMD_PROHIBIT_IN) begin
            stop[CMD_CODE_IN[0]] = 1'b1; // RULE_12
          end else if (interval_ok(unit_r, CMD_INTERVAL_IN)) begin
            start[CMD_CODE_IN[0]]     = 1'b1;
            clear_cnt[CMD_CODE_IN[0]] = 1'b1; // RULE_05
          end
        end
        default: ;
      endcase
    end else if (CMD_VALID_IN && CMD_OP_IN == SIIT_OP_CLEAR) begin
      // clear command resets the interval counter for a fixed first delay
      case (CMD_CODE_IN)
        `SIIT_CODE_CH0, `SIIT_CODE_CH1: clear_cnt[CMD_CODE_IN[0]] = 1'b1; // RULE_06
        default: ;
      endcase
    end
  end

  // register, prescaler and answer next values
  always_comb begin
    unit_nxt    = unit_r;
    unit_rd_nxt = unit_r;
    ival_nxt    = ival_r;
    pre_nxt     = pre_r;
    tick_nxt    = 1'b0;
    done_nxt    = 1'b0;
    err_nxt     = 1'b0;
    rdata_nxt   = rdata_r;
    irq_nxt     = fire;
    run_nxt     = running;
    if (SETUP_WR_IN && SETUP_ADDR_IN == `SIIT_UNIT_OFFSET) begin
      unit_nxt = SETUP_WDATA_IN; // RULE_01
    end
    // shared unit prescaler; the unit sets tick spacing for both channels
    if (pre_r + 32'h0000_0001 >= unit_cycles(unit_r)) begin
      pre_nxt  = 32'h0000_0000;
      tick_nxt = 1'b1; // RULE_02
    end else begin
      pre_nxt = pre_r + 32'h0000_0001;
    end
    if (CMD_VALID_IN) begin
      done_nxt = 1'b1;
      case (CMD_OP_IN)
        SIIT_OP_SET: begin
          if (CMD_CODE_IN != `SIIT_CODE_CH0 && CMD_CODE_IN != `SIIT_CODE_CH1 &&
              CMD_CODE_IN != `SIIT_CODE_CH0_RST && CMD_CODE_IN != `SIIT_CODE_CH1_RST) begin
            err_nxt = 1'b1;
          end else if (!CMD_PROHIBIT_IN) begin
            if (interval_ok(unit_r, CMD_INTERVAL_IN)) begin
              ival_nxt[CMD_CODE_IN[0]] = CMD_INTERVAL_IN; // RULE_02
            end else begin
              err_nxt = 1'b1; // RULE_03
            end
          end
        end
        SIIT_OP_READ: begin
          case (CMD_CODE_IN)
            `SIIT_CODE_CH0, `SIIT_CODE_CH1: rdata_nxt = ival_r[CMD_CODE_IN[0]]; // RULE_08
            // counter counts whole units of the selected unit
            `SIIT_CODE_CH0_RST, `SIIT_CODE_CH1_RST: begin
              rdata_nxt = elapsed[CMD_CODE_IN[0]]; // RULE_10
            end
            default: begin
              rdata_nxt = 16'h0000;
              err_nxt   = 1'b1;
            end
          endcase
        end
        SIIT_OP_CLEAR: begin
          if (CMD_CODE_IN != `SIIT_CODE_CH0 && CMD_CODE_IN != `SIIT_CODE_CH1) begin
            err_nxt = 1'b1;
          end
        end
        default: err_nxt = 1'b1;
      endcase
    end
  end

  always_ff @(posedge CLK_SYS_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      unit_r    <= `SIIT_UNIT_RESET;
      unit_rd_r <= `SIIT_UNIT_RESET;
      ival_r    <= '{16'h0000, 16'h0000};
      pre_r     <= 32'h0000_0000;
      tick_r    <= 1'b0;
      done_r    <= 1'b0;
      err_r     <= 1'b0;
      rdata_r   <= 16'h0000;
      irq_r     <= 2'b00;
      run_r     <= 2'b00;
    end else begin
      unit_r    <= unit_nxt;
      unit_rd_r <= unit_rd_nxt;
      ival_r    <= ival_nxt;
      pre_r     <= pre_nxt;
      tick_r    <= tick_nxt;
      done_r    <= done_nxt;
      err_r     <= err_nxt;
      rdata_r   <= rdata_nxt;
      irq_r     <= irq_nxt;
      run_r     <= run_nxt;
    end
  end

  // two identical channels; interval taken from the command when starting
  for (genvar i = 0; i < 2; i++) begin : g_ch
    siit_channel u_ch (
      .clk       (CLK_SYS_IN),
      .rst_b     (RST_B_IN),
      .tick      (tick_r),
      .start     (start[i]),
      .clear_cnt (clear_cnt[i]),
      .stop      (stop[i]),
      .interval  (start[i] ? CMD_INTERVAL_IN : ival_r[i]),
      .running   (running[i]),
      .elapsed   (elapsed[i]),
      .fire      (fire[i])
    );
  end

  assign SETUP_RDATA_OUT = unit_rd_r;
  assign CMD_DONE_OUT    = done_r;
  assign CMD_ERROR_OUT   = err_r;
  assign CMD_RDATA_OUT   = rdata_r;
  assign SCHED_IRQ_OUT   = irq_r; // RULE_13
  assign CH_RUNNING_OUT  = run_r;
endmodule : siit_timer
